// ===== design/mtr_debounce.sv
`include "mtr_params.svh"

module mtr_debounce
  import mtr_pkg::*;
#(
  parameter int               CNT_W   = `MTR_DEBOUNCE_CNT_W,
  parameter logic [CNT_W-1:0] CNT_MAX = CNT_W'(`MTR_DEBOUNCE_CYCLES)
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clear_i,
  input  wire logic raw_i,
  output logic      stable_o
);

  logic [CNT_W-1:0] cnt_r;

  // a level is taken only after it held for the whole window,
  // so contact bounce never reaches the register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r    <= '0;
      stable_o <= 1'b0;
    end else if (clear_i) begin
      cnt_r    <= '0;
      stable_o <= 1'b0;
    end else if (raw_i == stable_o) begin
      cnt_r <= '0;
    end else if (cnt_r == CNT_MAX - CNT_W'(1)) begin
      cnt_r    <= '0;
      stable_o <= raw_i;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

endmodule

// ===== design/mtr_params.svh
`ifndef MTR_PARAMS_SVH
`define MTR_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MTR_OFS_PRODUCT_CODE     8'h00
`define MTR_OFS_SILICON_REVISION 8'h01
`define MTR_OFS_BUTTON_STATE     8'h02
`define MTR_OFS_MOTION_X_LOW     8'h03
`define MTR_OFS_MOTION_Y_LOW     8'h04
`define MTR_OFS_MOTION_XY_HIGH   8'h05
`define MTR_OFS_WHEEL_COUNT      8'h06

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define MTR_BTN_ONE_BIT          0
`define MTR_BTN_TWO_BIT          1
`define MTR_BTN_THREE_BIT        2
`define MTR_HIGH_X_MSB           7
`define MTR_HIGH_X_LSB           4
`define MTR_HIGH_Y_MSB           3
`define MTR_HIGH_Y_LSB           0
`define MTR_RESET_BYTE           8'h00
`define MTR_RESET_MOTION         12'h000
`define MTR_MOTION_POS_LIMIT     12'h7FF
`define MTR_MOTION_NEG_LIMIT     12'h800
`define MTR_WHEEL_POS_LIMIT      8'h7F
`define MTR_WHEEL_NEG_LIMIT      8'h81
`define MTR_WHEEL_FORBIDDEN      8'h80

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MTR_CLK_PERIOD_NS        10
`define MTR_DEBOUNCE_NS          5000
`define MTR_DEBOUNCE_CYCLES \
  ((`MTR_DEBOUNCE_NS + `MTR_CLK_PERIOD_NS - 1) / `MTR_CLK_PERIOD_NS)
`define MTR_DEBOUNCE_CNT_W       10

`endif

// ===== design/mtr_pkg.sv
package mtr_pkg;

  // ----------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------
  typedef logic [7:0]         mtr_byte_t;
  typedef logic [7:0]         mtr_addr_t;
  typedef logic signed [11:0] mtr_motion_t;
  typedef logic signed [7:0]  mtr_wheel_t;

endpackage

// ===== design/mtr_readout_regs.sv
`include "mtr_params.svh"

module mtr_readout_regs
  import mtr_pkg::*;
#(
  parameter mtr_byte_t PRODUCT_CODE = 8'h5A, // value is arbitrary
  parameter mtr_byte_t REVISION     = 8'h01  // value is arbitrary
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         usb_reset_i,
  input  wire logic         button_one_input_i,
  input  wire logic         button_two_input_i,
  input  wire logic         button_three_input_i,
  input  wire logic         motion_valid_i,
  input  wire mtr_motion_t  motion_dx_i,
  input  wire mtr_motion_t  motion_dy_i,
  input  wire logic         wheel_step_i,
  input  wire logic         wheel_up_i,
  input  wire logic         report_load_i,
  input  wire logic         rd_req_i,
  input  wire mtr_addr_t    rd_addr_i,
  output mtr_byte_t         rd_data_o,
  output logic              rd_valid_o,
  output mtr_motion_t       report_x_o,
  output mtr_motion_t       report_y_o,
  output mtr_wheel_t        report_z_o,
  output logic [2:0]        button_state_o
);

  // ----------------------------------------------------------------
  // button debouncing
  // ----------------------------------------------------------------
  logic [2:0] btn_raw;
  logic [2:0] btn_deb;

  assign btn_raw[`MTR_BTN_ONE_BIT]   = button_one_input_i;
  assign btn_raw[`MTR_BTN_TWO_BIT]   = button_two_input_i;
  assign btn_raw[`MTR_BTN_THREE_BIT] = button_three_input_i;

  // one filter per button; all restart on a USB reset
  for (genvar i = 0; i < 3; i++) begin : g_deb
    mtr_debounce u_deb (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (usb_reset_i),
      .raw_i     (btn_raw[i]),
      .stable_o  (btn_deb[i])
    );
  end

  // the report port sees the same filtered levels as the register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      button_state_o <= 3'h0;
    end else begin
      button_state_o <= btn_deb;
    end
  end

  // ----------------------------------------------------------------
  // motion and wheel accumulation
  // ----------------------------------------------------------------
  mtr_motion_t acc_x_r;
  mtr_motion_t acc_y_r;
  mtr_wheel_t  acc_z_r;
  mtr_motion_t acc_x_nxt;
  mtr_motion_t acc_y_nxt;
  mtr_wheel_t  acc_z_nxt;

  // saturate instead of wrapping, so a fast swipe never flips sign
  function automatic mtr_motion_t sat_add12(mtr_motion_t a,
                                            mtr_motion_t b);
    logic signed [12:0] s;
    s = {a[11], a} + {b[11], b};
    if (s[12] != s[11]) begin
      sat_add12 = s[12] ? `MTR_MOTION_NEG_LIMIT
                        : `MTR_MOTION_POS_LIMIT;
    end else begin
      sat_add12 = s[11:0];
    end
  endfunction

  always_comb begin
    acc_x_nxt = sat_add12(acc_x_r, motion_dx_i);
    acc_y_nxt = sat_add12(acc_y_r, motion_dy_i);
    acc_z_nxt = acc_z_r;
    // the wheel stops one short of -128 to keep the range symmetric
    if (wheel_up_i && acc_z_r != `MTR_WHEEL_POS_LIMIT) begin
      acc_z_nxt = acc_z_r + 8'sh01;
    end else if (!wheel_up_i && acc_z_r != `MTR_WHEEL_NEG_LIMIT) begin
      acc_z_nxt = acc_z_r - 8'sh01;
    end
  end

  // a load empties the accumulators; a delta in that same cycle
  // becomes the new starting value so no movement is lost
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_x_r <= `MTR_RESET_MOTION;
      acc_y_r <= `MTR_RESET_MOTION;
    end else if (usb_reset_i) begin
      acc_x_r <= `MTR_RESET_MOTION;
      acc_y_r <= `MTR_RESET_MOTION;
    end else if (report_load_i) begin
      acc_x_r <= motion_valid_i ? motion_dx_i : `MTR_RESET_MOTION;
      acc_y_r <= motion_valid_i ? motion_dy_i : `MTR_RESET_MOTION;
    end else if (motion_valid_i) begin
      acc_x_r <= acc_x_nxt;
      acc_y_r <= acc_y_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_z_r <= `MTR_RESET_BYTE;
    end else if (usb_reset_i) begin
      acc_z_r <= `MTR_RESET_BYTE;
    end else if (report_load_i) begin
      if (wheel_step_i) begin
        acc_z_r <= wheel_up_i ? 8'sh01 : 8'shFF;
      end else begin
        acc_z_r <= `MTR_RESET_BYTE;
      end
    end else if (wheel_step_i) begin
      acc_z_r <= acc_z_nxt;
    end
  end

  // ----------------------------------------------------------------
  // reported sample
  // ----------------------------------------------------------------
  // these hold what was last handed to the report path
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      report_x_o <= `MTR_RESET_MOTION;
      report_y_o <= `MTR_RESET_MOTION;
      report_z_o <= `MTR_RESET_BYTE;
    end else if (usb_reset_i) begin
      report_x_o <= `MTR_RESET_MOTION;
      report_y_o <= `MTR_RESET_MOTION;
      report_z_o <= `MTR_RESET_BYTE;
    end else if (report_load_i) begin
      report_x_o <= acc_x_r;
      report_y_o <= acc_y_r;
      report_z_o <= acc_z_r;
    end
  end

  // ----------------------------------------------------------------
  // read ordering snapshot
  // ----------------------------------------------------------------
  logic      rd_x_low;
  logic      rd_y_low;
  logic      rd_high;
  logic      y_ok_r;
  logic      h_ok_r;
  mtr_byte_t snap_y_r;
  mtr_byte_t snap_h_r;

  assign rd_x_low = rd_req_i && rd_addr_i == `MTR_OFS_MOTION_X_LOW;
  assign rd_y_low = rd_req_i && rd_addr_i == `MTR_OFS_MOTION_Y_LOW;
  assign rd_high  = rd_req_i && rd_addr_i == `MTR_OFS_MOTION_XY_HIGH;

  // an X-low read freezes the partner bytes; each partner may be
  // read once, and a later report load cannot tear the sample
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      y_ok_r   <= 1'b0;
      h_ok_r   <= 1'b0;
      snap_y_r <= `MTR_RESET_BYTE;
      snap_h_r <= `MTR_RESET_BYTE;
    end else if (usb_reset_i) begin
      y_ok_r   <= 1'b0;
      h_ok_r   <= 1'b0;
      snap_y_r <= `MTR_RESET_BYTE;
      snap_h_r <= `MTR_RESET_BYTE;
    end else begin
      if (rd_x_low) begin
        y_ok_r   <= 1'b1;
        h_ok_r   <= 1'b1;
        snap_y_r <= report_y_o[7:0];
        snap_h_r <= {report_x_o[11:8], report_y_o[11:8]};
      end
      if (rd_y_low) begin
        y_ok_r <= 1'b0;
      end
      if (rd_high) begin
        h_ok_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // one answer per request, one cycle later, except that a request
  // while usb_reset_i is high gets none; unmapped offsets read as zero
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= `MTR_RESET_BYTE;
    end else begin
      rd_valid_o <= rd_req_i && !usb_reset_i;
      if (rd_req_i) begin
        unique case (rd_addr_i)
          `MTR_OFS_PRODUCT_CODE:     rd_data_o <= PRODUCT_CODE;
          `MTR_OFS_SILICON_REVISION: rd_data_o <= REVISION;
          `MTR_OFS_BUTTON_STATE:     rd_data_o <= {5'h00, btn_deb};
          `MTR_OFS_MOTION_X_LOW:     rd_data_o <= report_x_o[7:0];
          `MTR_OFS_MOTION_Y_LOW: begin
            rd_data_o <= y_ok_r ? snap_y_r : `MTR_RESET_BYTE;
          end
          `MTR_OFS_MOTION_XY_HIGH: begin
            rd_data_o <= h_ok_r ? snap_h_r : `MTR_RESET_BYTE;
          end
          `MTR_OFS_WHEEL_COUNT:      rd_data_o <= report_z_o;
          default:                   rd_data_o <= `MTR_RESET_BYTE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_x_read;
    rd_x_low && !usb_reset_i;
  endsequence

  sequence s_y_read;
    rd_y_low && !usb_reset_i;
  endsequence

  sequence s_h_read;
    rd_high && !usb_reset_i;
  endsequence

  AST_PRODUCT: assert property (
    rd_req_i && rd_addr_i == `MTR_OFS_PRODUCT_CODE && !usb_reset_i
      |=> rd_valid_o && rd_data_o == PRODUCT_CODE)
    else $error("product code read wrong");

  AST_REVISION: assert property (
    rd_req_i && rd_addr_i == `MTR_OFS_SILICON_REVISION
      |=> rd_data_o == REVISION)
    else $error("revision read wrong");

  AST_BUTTONS: assert property (
    rd_req_i && rd_addr_i == `MTR_OFS_BUTTON_STATE
      |=> rd_data_o == {5'h00, $past(btn_deb)})
    else $error("button state read wrong");

  AST_X_LOW: assert property (
    s_x_read |=> rd_data_o == $past(report_x_o[7:0]))
    else $error("x low read wrong");

  AST_Y_COHERENT: assert property (
    s_x_read ##1 s_y_read |=> rd_data_o == $past(report_y_o[7:0], 2))
    else $error("y low not from the x sample");

  AST_HIGH_COHERENT: assert property (
    s_x_read ##1 s_h_read
      |=> rd_data_o == {$past(report_x_o[11:8], 2),
                        $past(report_y_o[11:8], 2)})
    else $error("high byte not from the x sample");

  AST_Y_ORDER: assert property (
    rd_y_low && !y_ok_r |=> rd_data_o == `MTR_RESET_BYTE)
    else $error("y low read without x low not zero");

  AST_H_ORDER: assert property (
    rd_high && !h_ok_r |=> rd_data_o == `MTR_RESET_BYTE)
    else $error("high byte read without x low not zero");

  AST_ACC_CLEAR: assert property (
    report_load_i && !motion_valid_i && !wheel_step_i
      |=> acc_x_r == `MTR_RESET_MOTION && acc_y_r == `MTR_RESET_MOTION
          && acc_z_r == `MTR_RESET_BYTE)
    else $error("accumulators not cleared on load");

  AST_WHEEL_RANGE: assert property (
    acc_z_r != `MTR_WHEEL_FORBIDDEN && report_z_o != `MTR_WHEEL_FORBIDDEN)
    else $error("wheel count left its range");

  AST_USB_RESET: assert property (
    usb_reset_i |=> report_x_o == `MTR_RESET_MOTION && !y_ok_r && !h_ok_r)
    else $error("usb reset did not clear registers");

endmodule

// ===== verif/mtr_host_model.sv
// ----------------------------------------------------------------
// host side of the register read port
// ----------------------------------------------------------------
module mtr_host_model
  import mtr_pkg::*;
(
  input  wire logic      sys_clk_i,
  input  wire logic      rd_valid_i,
  input  wire mtr_byte_t rd_data_i,
  output logic           rd_req_o,
  output mtr_addr_t      rd_addr_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle port: no request, address parked
  initial begin
    rd_req_o  = 1'b0;
    rd_addr_o = 8'h00;
  end

  // one read reached through the usb control path
  // callers order X-low ahead of Y-low and high byte
  // the answer is bounded, so a dead port reports ok = 0
  task automatic read(input mtr_addr_t a, output mtr_byte_t d,
                      output bit ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge sys_clk_i);
    #1;
    rd_req_o  = 1'b1;
    rd_addr_o = a;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      #1;
      rd_req_o  = 1'b0;
      rd_addr_o = ~a; // released lines do not keep the old offset
      if (rd_valid_i === 1'b1) begin
        d  = rd_data_i;
        ok = 1'b1;
        break;
      end
    end
  endtask

  // two requests on consecutive edges, as the port allows; the
  // second address replaces the first while the request stays high
  task automatic read_pair(input mtr_addr_t a, input mtr_addr_t b,
                           output mtr_byte_t da, output mtr_byte_t db,
                           output bit ok);
    @(posedge sys_clk_i);
    #1;
    rd_req_o  = 1'b1;
    rd_addr_o = a;
    @(posedge sys_clk_i);
    #1;
    rd_addr_o = b;
    ok        = (rd_valid_i === 1'b1);
    da        = rd_data_i;
    @(posedge sys_clk_i);
    #1;
    rd_req_o  = 1'b0;
    rd_addr_o = ~b;
    ok        = ok && (rd_valid_i === 1'b1);
    db        = rd_data_i;
  endtask
endmodule

// ===== verif/mtr_readout_regs_tb.sv
// ----------------------------------------------------------------
// self-checking bench for the test readout registers
// ----------------------------------------------------------------
module mtr_readout_regs_tb;
  import mtr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam mtr_byte_t PCODE = 8'hA5; // value is arbitrary
  localparam mtr_byte_t REV   = 8'h3C; // value is arbitrary

  logic        sys_clk_i   = 1'b0;
  logic        reset_n_i   = 1'b0;
  logic        usb_reset_i = 1'b0;
  logic        btn1 = 1'b0, btn2 = 1'b0, btn3 = 1'b0;
  logic        motion_valid_i = 1'b0;
  mtr_motion_t dx = '0, dy = '0;
  logic        wheel_step_i = 1'b0, wheel_up_i = 1'b0;
  logic        report_load_i = 1'b0;
  logic        rd_req, rd_valid;
  mtr_addr_t   rd_addr;
  mtr_byte_t   rd_data;
  mtr_motion_t rep_x, rep_y;
  mtr_wheel_t  rep_z;
  logic [2:0]  btn_state;
  int          error_cnt   = 0;
  int          checks_done = 0;

  mtr_readout_regs #(.PRODUCT_CODE(PCODE), .REVISION(REV)) i_mtr_readout_regs (
    .sys_clk_i           (sys_clk_i),
    .reset_n_i           (reset_n_i),
    .usb_reset_i         (usb_reset_i),
    .button_one_input_i  (btn1),
    .button_two_input_i  (btn2),
    .button_three_input_i(btn3),
    .motion_valid_i      (motion_valid_i),
    .motion_dx_i         (dx),
    .motion_dy_i         (dy),
    .wheel_step_i        (wheel_step_i),
    .wheel_up_i          (wheel_up_i),
    .report_load_i       (report_load_i),
    .rd_req_i            (rd_req),
    .rd_addr_i           (rd_addr),
    .rd_data_o           (rd_data),
    .rd_valid_o          (rd_valid),
    .report_x_o          (rep_x),
    .report_y_o          (rep_y),
    .report_z_o          (rep_z),
    .button_state_o      (btn_state)
  );

  mtr_host_model i_mtr_host_model (
    .sys_clk_i (sys_clk_i),
    .rd_valid_i(rd_valid),
    .rd_data_i (rd_data),
    .rd_req_o  (rd_req),
    .rd_addr_o (rd_addr)
  );

  // 100 MHz clock
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask

  task automatic chk8(input mtr_byte_t got, input mtr_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk12(input mtr_motion_t got, input mtr_motion_t exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a dead read port ends the run at once
  task automatic rd(input mtr_addr_t a, input mtr_byte_t exp);
    mtr_byte_t d;
    bit        ok;
    i_mtr_host_model.read(a, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("ERROR t=%0t read timeout addr=%h exp=%h", $time, a, exp);
      finish_test();
    end else begin
      chk8(d, exp);
    end
  endtask

  // two reads on consecutive edges; a missing answer ends the run
  task automatic rd2(input mtr_addr_t a, input mtr_addr_t b,
                     input mtr_byte_t ea, input mtr_byte_t eb);
    mtr_byte_t da;
    mtr_byte_t db;
    bit        ok;
    i_mtr_host_model.read_pair(a, b, da, db, ok);
    if (!ok) begin
      error_cnt++;
      $display("ERROR t=%0t pair timeout addr=%h exp=%h", $time, b, eb);
      finish_test();
    end else begin
      chk8(da, ea);
      chk8(db, eb);
    end
  endtask

  task automatic move(input mtr_motion_t x, input mtr_motion_t y);
    motion_valid_i = 1'b1;
    dx = x;
    dy = y;
    tick(1);
    motion_valid_i = 1'b0;
    tick(1); // let the low level stand before the next call raises it
  endtask

  task automatic load();
    report_load_i = 1'b1;
    tick(1);
    report_load_i = 1'b0;
    tick(1);
  endtask

  task automatic wheel(input logic up, input int n);
    wheel_up_i   = up;
    wheel_step_i = 1'b1;
    tick(n);
    wheel_step_i = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mtr_motion_t x, y;
    tick(2);
    reset_n_i = 1'b1;
    // identity, buttons, motion and an unmapped offset after reset
    rd(8'h00, PCODE);
    rd(8'h01, REV);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h00, PCODE);
    $display("test reset_values done");
    // negative X, positive Y, read in the intended order
    x = 12'hABC;
    y = 12'h123;
    move(x, y);
    load();
    chk12(rep_x, x);
    rd(8'h03, x[7:0]);
    move(12'h005, 12'h006); // later motion must not leak into the sample
    load();
    rd(8'h04, y[7:0]);
    rd(8'h05, {x[11:8], y[11:8]});
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    $display("test ordered_read done");
    // accumulate, saturate and clear on load
    move(12'hFFB, 12'h700);
    move(12'h003, 12'h700);
    load();
    chk12(rep_x, 12'hFFE);
    chk12(rep_y, 12'h7FF);
    rd(8'h03, 8'hFE);
    rd(8'h05, 8'hF7);
    move(12'h900, 12'h000);
    move(12'h900, 12'h000);
    load();
    chk12(rep_x, 12'h800);
    load();
    chk12(rep_x, 12'h000);
    rd(8'h03, 8'h00);
    $display("test accumulate done");
    // wheel limits in both directions
    wheel(1'b0, 200);
    load();
    rd(8'h06, 8'h81);
    wheel(1'b1, 130);
    load();
    rd(8'h06, 8'h7F);
    chk8(rep_z, 8'h7F);
    $display("test wheel done");
    // buttons only show once debounced
    btn2 = 1'b1;
    tick(300);
    rd(8'h02, 8'h00);
    tick(300);
    rd(8'h02, 8'h02);
    btn1 = 1'b1;
    btn3 = 1'b1;
    tick(600);
    rd(8'h02, 8'h07);
    chk8({5'h00, btn_state}, 8'h07);
    $display("test buttons done");
    // back-to-back reads, then usb reset clears report and snapshots
    move(12'h355, 12'hC66);
    load();
    rd2(8'h03, 8'h04, 8'h55, 8'h66);
    rd2(8'h03, 8'h05, 8'h55, 8'h3C);
    usb_reset_i = 1'b1;
    tick(1);
    usb_reset_i = 1'b0;
    tick(1);
    chk12(rep_x, 12'h000);
    rd(8'h04, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h00, PCODE);
    $display("test usb_reset done");
    finish_test();
  end
endmodule
